// ===== rtl/led_defines.vh
`ifndef LED_DEFINES_VH
`define LED_DEFINES_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define ADDR_W              5
`define DATA_W              16
`define LED_INDICATOR_CONFIG 5'h18
`define LED_MANUAL_OVERRIDE  5'h19

// ----------------------------------------------------------------------
// Indicator configuration fields
// ----------------------------------------------------------------------
`define CFG_DISABLE_BIT     15
`define CFG_ON_HI           14
`define CFG_ON_LO           12
`define CFG_OFF_HI          10
`define CFG_OFF_LO          8
`define CFG_LINK_HI         4
`define CFG_LINK_LO         3
`define CFG_DUPLEX_BIT      2
`define CFG_RX_BIT          1
`define CFG_TX_BIT          0
`define CFG_ON_RESET        3'h4
`define CFG_OFF_RESET       3'h1
`define LINK_DIRECT         2'h0
`define LINK_COMBINED_A     2'h1
`define LINK_COMBINED_B     2'h2
`define LINK_MASTER_SLAVE   2'h3

// ----------------------------------------------------------------------
// Manual override fields and codes
// ----------------------------------------------------------------------
`define OVR_DUPLEX_LO       10
`define OVR_SLOW_LO         8
`define OVR_FAST_LO         6
`define OVR_SPARE_LO        4
`define OVR_RX_LO           2
`define OVR_TX_LO           0
`define OVR_NORMAL          2'h0
`define OVR_BLINK           2'h1
`define OVR_OFF             2'h2
`define OVR_ON              2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       40
`define MS_NS               1000000
// One millisecond of 40 ns cycles, sized to the divider width
`define MS_CYCLES           16'h61A8
`define DUR_W               9
`define T_10MS              9'h00A
`define T_21MS              9'h015
`define T_42MS              9'h02A
`define T_84MS              9'h054
`define T_168MS             9'h0A8
`define T_330MS             9'h14A

`endif

// ===== rtl/ms_tick.v
`timescale 1ns/1ps
`include "led_defines.vh"

module ms_tick #(
  parameter [15:0] DIV = 16'h61A8
) (
  input  wire ref_clk,
  input  wire rstn,
  output reg  tick_r
);

  reg [15:0] cnt_r;

  // Free running divider, one pulse per millisecond
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else if (cnt_r == DIV - 16'h0001) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

endmodule

// ===== rtl/blink_timer.v
`timescale 1ns/1ps
`include "led_defines.vh"

module blink_timer (
  input  wire               ref_clk,
  input  wire               rstn,
  input  wire               sw_rst,
  input  wire               ms_en,
  input  wire [`DUR_W-1:0]  on_ms,
  input  wire [`DUR_W-1:0]  off_ms,
  output reg                lit_r,
  output reg                cycle_end_r
);

  reg [`DUR_W-1:0] ms_cnt_r;
  reg              phase_r;

  // Lit phase then dark phase; a changed duration applies to the running
  // phase. The visible phase lags phase_r by one cycle, so a hold cleared
  // on cycle_end_r drops on the same edge as the lit phase ends
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ms_cnt_r    <= {`DUR_W{1'b0}};
      phase_r     <= 1'b1;
      lit_r       <= 1'b1;
      cycle_end_r <= 1'b0;
    end else if (sw_rst) begin
      ms_cnt_r    <= {`DUR_W{1'b0}};
      phase_r     <= 1'b1;
      lit_r       <= 1'b1;
      cycle_end_r <= 1'b0;
    end else begin
      lit_r       <= phase_r;
      cycle_end_r <= 1'b0;
      if (ms_en) begin
        if (ms_cnt_r + 9'h001 >= (phase_r ? on_ms : off_ms)) begin
          ms_cnt_r    <= {`DUR_W{1'b0}};
          phase_r     <= ~phase_r;        // R11
          cycle_end_r <= phase_r;         // End of a lit phase
        end else begin
          ms_cnt_r <= ms_cnt_r + 9'h001;
        end
      end
    end
  end

endmodule

// ===== rtl/led_indicator_ctrl.v
// Notes on behaviour
// R01: On-time code 1..5 gives 10,21,42,84,168 ms; 6,7 give 42; reset 4.
// R02: Off-time code 0..4 gives 21,42,84,168,330 ms; 5..7 give 168; reset 1.
// R03: Bit 15 of configuration disables all indicators when set; reset 0.
// R04: Link mode bits 4:3: 00 direct, 11 master/slave, 01/10 combined.
// R05: Duplex select bit 2: duplex only, or duplex with collision blinks.
// R06: Receive select bit 1: receive activity, or activity combined with link.
// R07: Transmit select bit 0: transmit activity, or any activity with link.
// R08: LED pin high means off, low means on.
// R09: Two-bit overrides: normal, blink, off, on for each of five indicators.
// R10: Hardware reset loads defaults; software reset keeps programmed fields.
// R11: Blinking alternates the programmed on-duration and off-duration.
// R12: Global disable holds every pin high, overriding all overrides.
`timescale 1ns/1ps
`include "led_defines.vh"

module led_indicator_ctrl #(
  parameter [15:0] MS_DIV = `MS_CYCLES
) (
  input  wire               ref_clk,
  input  wire               rstn,
  input  wire               sw_rst,
  input  wire [`ADDR_W-1:0] addr,
  input  wire [`DATA_W-1:0] wr_data,
  input  wire               wr_en,
  input  wire               rd_en,
  output reg  [`DATA_W-1:0] rd_data,
  input  wire               link_up,
  input  wire               speed_100,
  input  wire               full_duplex,
  input  wire               collision,
  input  wire               rx_active,
  input  wire               tx_active,
  output reg                duplex_led_n,
  output reg                slow_link_indicator_n,
  output reg                fast_link_indicator_n,
  output reg                rx_led_n,
  output reg                tx_led_n
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  reg        led_disable_r;
  reg [2:0]  on_code_r;
  reg [2:0]  off_code_r;
  reg [1:0]  link_mode_r;
  reg        duplex_sel_r;
  reg        rx_sel_r;
  reg        tx_sel_r;
  reg [1:0]  ovr_duplex_r;
  reg [1:0]  ovr_slow_r;
  reg [1:0]  ovr_fast_r;
  reg [1:0]  ovr_spare_r;
  reg [1:0]  ovr_rx_r;
  reg [1:0]  ovr_tx_r;

  reg        rx_hold_r;
  reg        tx_hold_r;
  reg        col_hold_r;

  wire       ms_en;
  wire       blink_lit;
  wire       cycle_end;
  wire [8:0] on_ms;
  wire [8:0] off_ms;
  wire       cfg_hit;
  wire       ovr_hit;

  reg        duplex_norm;
  reg        slow_norm;
  reg        fast_norm;
  reg        rx_norm;
  reg        tx_norm;
  reg [15:0] rd_nxt;

  // --------------------------------------------------------------------
  // Duration decode
  // --------------------------------------------------------------------

  // Code 000 is not defined for the lit time; it falls to 42 ms
  function [8:0] on_decode;
    input [2:0] code;
    begin
      case (code)
        3'h1:    on_decode = `T_10MS;   // R01
        3'h2:    on_decode = `T_21MS;   // R01
        3'h3:    on_decode = `T_42MS;   // R01
        3'h4:    on_decode = `T_84MS;   // R01
        3'h5:    on_decode = `T_168MS;  // R01
        default: on_decode = `T_42MS;   // R01
      endcase
    end
  endfunction

  // Dark time; the upper reserved codes fall to 168 ms
  function [8:0] off_decode;
    input [2:0] code;
    begin
      case (code)
        3'h0:    off_decode = `T_21MS;   // R02
        3'h1:    off_decode = `T_42MS;   // R02
        3'h2:    off_decode = `T_84MS;   // R02
        3'h3:    off_decode = `T_168MS;  // R02
        3'h4:    off_decode = `T_330MS;  // R02
        default: off_decode = `T_168MS;  // R02
      endcase
    end
  endfunction

  // Override decode: normal level, blink phase, forced off or forced on
  function lit_sel;
    input [1:0] mode;
    input       normal;
    input       blink;
    begin
      case (mode)
        `OVR_NORMAL: lit_sel = normal;  // R09
        `OVR_BLINK:  lit_sel = blink;   // R09
        `OVR_OFF:    lit_sel = 1'b0;    // R09
        `OVR_ON:     lit_sel = 1'b1;    // R09
        default:     lit_sel = normal;
      endcase
    end
  endfunction

  assign on_ms  = on_decode(on_code_r);
  assign off_ms = off_decode(off_code_r);

  // --------------------------------------------------------------------
  // Timebase and blink phase
  // --------------------------------------------------------------------

  // One shared blink phase keeps all indicators in step
  // Forced blink and activity blink share it, so lamps never drift apart
  ms_tick #(
    .DIV (MS_DIV)
  ) u_ms_tick (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tick_r  (ms_en)
  );

  blink_timer u_blink (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .sw_rst      (sw_rst),
    .ms_en       (ms_en),
    .on_ms       (on_ms),
    .off_ms      (off_ms),
    .lit_r       (blink_lit),
    .cycle_end_r (cycle_end)
  );

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  assign cfg_hit = (addr == `LED_INDICATOR_CONFIG);
  assign ovr_hit = (addr == `LED_MANUAL_OVERRIDE);

  // Only the hardware reset reloads defaults; software reset is ignored
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      led_disable_r <= 1'b0;                   // R10
      on_code_r     <= `CFG_ON_RESET;          // R10
      off_code_r    <= `CFG_OFF_RESET;         // R10
      link_mode_r   <= `LINK_DIRECT;           // R10
      duplex_sel_r  <= 1'b0;
      rx_sel_r      <= 1'b0;
      tx_sel_r      <= 1'b0;
    end else if (wr_en && cfg_hit) begin
      led_disable_r <= wr_data[`CFG_DISABLE_BIT];                // R03
      on_code_r     <= wr_data[`CFG_ON_HI:`CFG_ON_LO];           // R01
      off_code_r    <= wr_data[`CFG_OFF_HI:`CFG_OFF_LO];         // R02
      link_mode_r   <= wr_data[`CFG_LINK_HI:`CFG_LINK_LO];       // R04
      duplex_sel_r  <= wr_data[`CFG_DUPLEX_BIT];                 // R05
      rx_sel_r      <= wr_data[`CFG_RX_BIT];                     // R06
      tx_sel_r      <= wr_data[`CFG_TX_BIT];                     // R07
    end
  end

  // Override fields, same reset policy as the configuration
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ovr_duplex_r <= `OVR_NORMAL;             // R10
      ovr_slow_r   <= `OVR_NORMAL;
      ovr_fast_r   <= `OVR_NORMAL;
      ovr_spare_r  <= 2'h0;
      ovr_rx_r     <= `OVR_NORMAL;
      ovr_tx_r     <= `OVR_NORMAL;
    end else if (wr_en && ovr_hit) begin
      ovr_duplex_r <= wr_data[`OVR_DUPLEX_LO+1:`OVR_DUPLEX_LO];  // R09
      ovr_slow_r   <= wr_data[`OVR_SLOW_LO+1:`OVR_SLOW_LO];      // R09
      ovr_fast_r   <= wr_data[`OVR_FAST_LO+1:`OVR_FAST_LO];      // R09
      ovr_spare_r  <= wr_data[`OVR_SPARE_LO+1:`OVR_SPARE_LO];
      ovr_rx_r     <= wr_data[`OVR_RX_LO+1:`OVR_RX_LO];          // R09
      ovr_tx_r     <= wr_data[`OVR_TX_LO+1:`OVR_TX_LO];          // R09
    end
  end

  // --------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------

  // Reserved and read-only bits return zero; unmapped addresses read zero
  always @* begin
    rd_nxt = 16'h0000;
    if (cfg_hit) begin
      rd_nxt[`CFG_DISABLE_BIT]          = led_disable_r;
      rd_nxt[`CFG_ON_HI:`CFG_ON_LO]     = on_code_r;
      rd_nxt[`CFG_OFF_HI:`CFG_OFF_LO]   = off_code_r;
      rd_nxt[`CFG_LINK_HI:`CFG_LINK_LO] = link_mode_r;
      rd_nxt[`CFG_DUPLEX_BIT]           = duplex_sel_r;
      rd_nxt[`CFG_RX_BIT]               = rx_sel_r;
      rd_nxt[`CFG_TX_BIT]               = tx_sel_r;
    end else if (ovr_hit) begin
      rd_nxt[`OVR_DUPLEX_LO+1:`OVR_DUPLEX_LO] = ovr_duplex_r;
      rd_nxt[`OVR_SLOW_LO+1:`OVR_SLOW_LO]     = ovr_slow_r;
      rd_nxt[`OVR_FAST_LO+1:`OVR_FAST_LO]     = ovr_fast_r;
      rd_nxt[`OVR_SPARE_LO+1:`OVR_SPARE_LO]   = ovr_spare_r;
      rd_nxt[`OVR_RX_LO+1:`OVR_RX_LO]         = ovr_rx_r;
      rd_nxt[`OVR_TX_LO+1:`OVR_TX_LO]         = ovr_tx_r;
    end
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      rd_data <= rd_nxt;
    end else begin
      rd_data <= 16'h0000;
    end
  end

  // --------------------------------------------------------------------
  // Activity stretching
  // --------------------------------------------------------------------

  // Short packets would be invisible; hold each event until the current
  // or next lit phase ends, so it is always shown for part of a lit phase.
  // The clear lands on the edge where the lamp goes dark, so no one-cycle
  // flash or gap appears; a new event wins over the clear
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_hold_r  <= 1'b0;
      tx_hold_r  <= 1'b0;
      col_hold_r <= 1'b0;
    end else if (sw_rst) begin
      rx_hold_r  <= 1'b0;
      tx_hold_r  <= 1'b0;
      col_hold_r <= 1'b0;
    end else begin
      rx_hold_r  <= rx_active | (rx_hold_r & ~cycle_end);   // R11
      tx_hold_r  <= tx_active | (tx_hold_r & ~cycle_end);   // R11
      col_hold_r <= collision | (col_hold_r & ~cycle_end);  // R11
    end
  end

  // --------------------------------------------------------------------
  // Normal indicator levels
  // --------------------------------------------------------------------

  // Activity shown as the blink pattern while an event is held
  always @* begin
    duplex_norm = full_duplex;                                  // R05
    if (duplex_sel_r && col_hold_r) begin
      duplex_norm = blink_lit;                                  // R05
    end
    if (rx_sel_r) begin
      rx_norm = link_up & (rx_hold_r ? blink_lit : 1'b1);       // R06
    end else begin
      rx_norm = rx_hold_r & blink_lit;                          // R06
    end
    if (tx_sel_r) begin
      tx_norm = link_up &
                ((rx_hold_r | tx_hold_r) ? blink_lit : 1'b1);   // R07
    end else begin
      tx_norm = tx_hold_r & blink_lit;                          // R07
    end
    case (link_mode_r)
      `LINK_DIRECT: begin
        slow_norm = link_up & ~speed_100;                       // R04
        fast_norm = link_up & speed_100;                        // R04
      end
      `LINK_COMBINED_A: begin
        slow_norm = link_up & ~speed_100 &
                    ((rx_hold_r | tx_hold_r) ? blink_lit : 1'b1);
        fast_norm = link_up & speed_100 &
                    ((rx_hold_r | tx_hold_r) ? blink_lit : 1'b1); // R04
      end
      `LINK_COMBINED_B: begin
        slow_norm = link_up &
                    ((rx_hold_r | tx_hold_r) ? blink_lit : 1'b1);
        fast_norm = link_up & speed_100;                        // R04
      end
      `LINK_MASTER_SLAVE: begin
        slow_norm = link_up & ~speed_100;                       // R04
        fast_norm = link_up;                                    // R04
      end
      default: begin
        slow_norm = 1'b0;
        fast_norm = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------

  // Pins are active low; disable wins over every override
  // Registered so a decode change never glitches a lamp
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      duplex_led_n          <= 1'b1;
      slow_link_indicator_n <= 1'b1;
      fast_link_indicator_n <= 1'b1;
      rx_led_n              <= 1'b1;
      tx_led_n              <= 1'b1;
    end else if (led_disable_r) begin
      duplex_led_n          <= 1'b1;   // R12
      slow_link_indicator_n <= 1'b1;   // R12
      fast_link_indicator_n <= 1'b1;   // R12
      rx_led_n              <= 1'b1;   // R12
      tx_led_n              <= 1'b1;   // R12
    end else begin
      duplex_led_n <=
        ~lit_sel(ovr_duplex_r, duplex_norm, blink_lit);  // R08
      slow_link_indicator_n <=
        ~lit_sel(ovr_slow_r, slow_norm, blink_lit);      // R08
      fast_link_indicator_n <=
        ~lit_sel(ovr_fast_r, fast_norm, blink_lit);      // R08
      rx_led_n <=
        ~lit_sel(ovr_rx_r, rx_norm, blink_lit);          // R08
      tx_led_n <=
        ~lit_sel(ovr_tx_r, tx_norm, blink_lit);          // R08
    end
  end

endmodule

// ===== verification/led_indicator_chk.sv
`timescale 1ns/1ps
`include "led_defines.vh"

module led_indicator_chk #(
  parameter [15:0] MS_DIV = 16'h0004
) (
  input wire        ref_clk,
  input wire        rstn,
  input wire        sw_rst,
  input wire [4:0]  addr,
  input wire [15:0] wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [15:0] rd_data,
  input wire        link_up,
  input wire        speed_100,
  input wire        full_duplex,
  input wire        collision,
  input wire        rx_active,
  input wire        tx_active,
  input wire        duplex_led_n,
  input wire        slow_link_indicator_n,
  input wire        fast_link_indicator_n,
  input wire        rx_led_n,
  input wire        tx_led_n
);
  // ------------------------------------------------------------------
  // Shadow registers
  // ------------------------------------------------------------------
  reg [15:0] cfg_r;
  reg [15:0] ovr_r;
  reg [1:0]  up_r;

  // Built from bus writes only; up_r masks the first edges after reset
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= 16'h4100;
      ovr_r <= 16'h0000;
      up_r  <= 2'b00;
    end else begin
      up_r <= {up_r[0], 1'b1};
      if (wr_en && addr == `LED_INDICATOR_CONFIG)
        cfg_r <= wr_data;
      if (wr_en && addr == `LED_MANUAL_OVERRIDE)
        ovr_r <= wr_data;
    end
  end

  // Conditions under which a pin level is fully determined
  wire dis      = up_r[1] && cfg_r[15];
  wire run      = up_r[1] && !cfg_r[15];
  wire frc_on   = run && ovr_r[1:0] == 2'b11;
  wire frc_off  = run && ovr_r[11:10] == 2'b10;
  wire fast_dir = run && ovr_r[9:6] == 4'h0 && cfg_r[4:3] == 2'b00
                  && link_up && speed_100;
  wire ms_mode  = run && ovr_r[7:6] == 2'b00 && cfg_r[4:3] == 2'b11
                  && link_up;
  wire dup_dir  = run && ovr_r[11:10] == 2'b00 && !cfg_r[2];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_cfg_readback: assert property (
    rd_en && addr == `LED_INDICATOR_CONFIG
    |=> rd_data == ($past(cfg_r) & 16'hF71F))
    else $error("config read back differs from last write");
  a_ovr_readback: assert property (rd_en && addr == `LED_MANUAL_OVERRIDE
    |=> rd_data == ($past(ovr_r) & 16'h0FFF))
    else $error("override read back differs from last write");
  a_disable_dark: assert property (dis && $past(dis)
    |-> {duplex_led_n, slow_link_indicator_n, fast_link_indicator_n,
         rx_led_n, tx_led_n} == 5'h1F)
    else $error("pin lit while indicators disabled");
  a_force_on: assert property (frc_on && $past(frc_on) |-> !tx_led_n)
    else $error("forced-on transmit pin not low");
  a_force_off: assert property (frc_off [*2] |-> duplex_led_n)
    else $error("forced-off duplex pin not high");
  a_link_direct: assert property (fast_dir && $past(fast_dir)
    |-> !fast_link_indicator_n && slow_link_indicator_n)
    else $error("direct link mode pins wrong at fast speed");
  a_master_slave: assert property (ms_mode && $past(ms_mode)
    |-> !fast_link_indicator_n)
    else $error("master/slave mode fast pin not lit with link");
  a_duplex_plain: assert property (dup_dir && $past(dup_dir)
    |-> duplex_led_n == !$past(full_duplex))
    else $error("duplex pin does not follow duplex state");

  c_disabled: cover property (dis);
  c_forced_on: cover property (frc_on);
  c_cfg_read: cover property (rd_en && addr == `LED_INDICATOR_CONFIG);
endmodule

bind led_indicator_ctrl led_indicator_chk #(.MS_DIV(MS_DIV))
  i_led_indicator_chk (
  .ref_clk(ref_clk), .rstn(rstn), .sw_rst(sw_rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex),
  .collision(collision), .rx_active(rx_active), .tx_active(tx_active),
  .duplex_led_n(duplex_led_n), .slow_link_indicator_n(slow_link_indicator_n),
  .fast_link_indicator_n(fast_link_indicator_n), .rx_led_n(rx_led_n),
  .tx_led_n(tx_led_n));

// ===== verification/led_panel.sv
`timescale 1ns/1ps

module led_panel (
  input  wire  [4:0] pins_n,
  input  wire        ref_clk,
  output logic [4:0] lit,
  output int         lit_len [5],
  output int         dark_len [5],
  output int         edges [5]
);
  // ------------------------------------------------------------------
  // Lamp model
  // ------------------------------------------------------------------
  logic [4:0] prev;
  int         run [5];

  // A lamp glows while its pin is pulled low
  assign lit = ~pins_n;

  // Run lengths in clock cycles; the first run seen is usually partial
  always @(posedge ref_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (lit[i] !== prev[i]) begin
        if (prev[i] === 1'b1)
          lit_len[i] <= run[i];
        else
          dark_len[i] <= run[i];
        run[i] <= 1;
        edges[i] <= edges[i] + 1;
      end else begin
        run[i] <= run[i] + 1;
      end
    end
    prev <= lit;
  end
endmodule

// ===== verification/tb_led_indicator_ctrl.sv
`timescale 1ns/1ps
`include "led_defines.vh"

module tb_led_indicator_ctrl;
  localparam int MSD = 4;
  logic        ref_clk, rstn, sw_rst, wr_en, rd_en;
  logic [4:0]  addr;
  logic [15:0] wr_data;
  wire  [15:0] rd_data;
  logic        link_up, speed_100, full_duplex;
  logic        collision, rx_active, tx_active;
  wire  [4:0]  pins_n;
  wire  [4:0]  lit;
  int          lit_len [5];
  int          dark_len [5];
  int          edges [5];
  int          num_errors = 0;
  int          samples_checked = 0;
  int          on_tab [8] = '{42, 10, 21, 42, 84, 168, 42, 42};
  int          off_tab [8] = '{21, 42, 84, 168, 330, 168, 168, 168};
  int          sh [5] = '{10, 8, 6, 2, 0};
  int          e, n;

  led_indicator_ctrl #(.MS_DIV(16'(MSD))) i_led_indicator_ctrl (
    .ref_clk(ref_clk), .rstn(rstn), .sw_rst(sw_rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex),
    .collision(collision), .rx_active(rx_active), .tx_active(tx_active),
    .duplex_led_n(pins_n[4]), .slow_link_indicator_n(pins_n[3]),
    .fast_link_indicator_n(pins_n[2]), .rx_led_n(pins_n[1]),
    .tx_led_n(pins_n[0]));

  led_panel i_led_panel (.pins_n(pins_n), .ref_clk(ref_clk), .lit(lit),
    .lit_len(lit_len), .dark_len(dark_len), .edges(edges));

  // ------------------------------------------------------------------
  // Clock, watchdog and verdict
  // ------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Blink table needs about 20k cycles; allow well over twice that
  initial begin
    #(60000 * 40);
    num_errors++;
    summarize();
  end

  task summarize;
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Compare and bus tasks
  // ------------------------------------------------------------------
  task cmp16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  task cmp5(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: pins %b, expected %b", $time, got, exp);
    end
  endtask

  // Phase ends are quantised to the millisecond tick, hence the margin
  task cmp_near(input int got, input int exp);
    samples_checked++;
    if (got < exp - MSD || got > exp + MSD) begin
      num_errors++;
      $display("Error %0t: run %0d cycles, expected %0d", $time, got, exp);
    end
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 cmp16(rd_data, exp);
  endtask

  task pins(input logic [4:0] exp);
    repeat (3) @(posedge ref_clk);
    #1 cmp5(pins_n, exp);
  endtask

  // Pulse one activity input and wait for its lamp to come on
  task act(input int k);
    @(posedge ref_clk);
    {collision, rx_active, tx_active} <= 3'b001 << (k == 4 ? 2 : k);
    @(posedge ref_clk);
    {collision, rx_active, tx_active} <= 3'b000;
    n = 0;
    while (pins_n[k] !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    cmp5(pins_n & (5'h01 << k), 5'h00);
  endtask

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    sw_rst = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 5'h00;
    wr_data = 16'h0000;
    {link_up, speed_100, full_duplex} = 3'b000;
    {collision, rx_active, tx_active} = 3'b000;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`LED_INDICATOR_CONFIG, 16'h4100);
    rd(`LED_MANUAL_OVERRIDE, 16'h0000);
    pins(5'h1F);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    rd(`LED_INDICATOR_CONFIG, 16'h4100);
    $display("test reset done");
    wr(`LED_INDICATOR_CONFIG, 16'hFFFF);
    wr(`LED_MANUAL_OVERRIDE, 16'hFFFF);
    rd(`LED_INDICATOR_CONFIG, 16'hF71F);
    rd(`LED_MANUAL_OVERRIDE, 16'h0FFF);
    pins(5'h1F);
    @(posedge ref_clk);
    sw_rst <= 1'b1;
    @(posedge ref_clk);
    sw_rst <= 1'b0;
    rd(`LED_INDICATOR_CONFIG, 16'hF71F);
    rd(`LED_MANUAL_OVERRIDE, 16'h0FFF);
    wr(`LED_INDICATOR_CONFIG, 16'h4100);
    pins(5'h00);
    wr(`LED_MANUAL_OVERRIDE, 16'h0AAA);
    pins(5'h1F);
    for (int i = 0; i < 5; i++) begin
      wr(`LED_MANUAL_OVERRIDE, 16'h0003 << sh[i]);
      pins(5'h1F ^ (5'h10 >> i));
    end
    $display("test storage done");
    wr(`LED_MANUAL_OVERRIDE, 16'h0000);
    {link_up, speed_100, full_duplex} <= 3'b111;
    pins(5'b01011);
    wr(`LED_INDICATOR_CONFIG, 16'h411B);
    {link_up, speed_100, full_duplex} <= 3'b101;
    pins(5'b00000);
    wr(`LED_INDICATOR_CONFIG, 16'h4100);
    pins(5'b00111);
    wr(`LED_INDICATOR_CONFIG, 16'h4110);
    {link_up, speed_100, full_duplex} <= 3'b111;
    pins(5'b00011);
    wr(`LED_INDICATOR_CONFIG, 16'h4108);
    pins(5'b01011);
    act(1);
    act(0);
    wr(`LED_INDICATOR_CONFIG, 16'h4104);
    full_duplex <= 1'b0;
    act(4);
    $display("test status done");
    wr(`LED_MANUAL_OVERRIDE, 16'h0555);
    for (int c = 0; c < 8; c++) begin
      wr(`LED_INDICATOR_CONFIG, {1'b0, c[2:0], 1'b0, c[2:0], 8'h00});
      e = edges[0];
      n = 0;
      while (edges[0] < e + 5 && n < 8000) begin
        @(posedge ref_clk);
        n++;
      end
      cmp16(16'(edges[0] - e), 16'h0005);
      for (int k = 0; k < 5; k++) begin
        cmp_near(lit_len[k], on_tab[c] * MSD);
        cmp_near(dark_len[k], off_tab[c] * MSD);
      end
    end
    $display("test blink done");
    summarize();
  end
endmodule
